/* src/call_return_stack.sv */
`timescale 1ns/10ps
`include "call_return_stack_defs.svh"
// Operation
// - The stack pointer is a 2-bit field in bits 1:0 of an 8-bit register, reset to 11, rest zero.
// - Each slot holds an 11-bit address, bits 10:8 in the high byte 2:0, bits 7:0 in the low byte.
// - A push decrements the pointer by one and a pop increments it by one.
// - A call saves the program counter plus one into the pointed slot, then loads the call target.
// - The stack is last-in first-out.
// - A return pops the latest call, increments the pointer and reloads the program counter.
// - Pushes from pointer 11 fill slots 0,1,2,3 leaving 10,01,00,11; a fifth push is overflow.
// - Pops read slot 3, 2, 1, 0 in turn and leave the pointer back at 11.
// - Pointer at 0DFH and slot bytes at 0F0H to 0F7H are readable, writable; slots reset to 0.
// - Any reset stops execution, restores pointer and slots and clears the program counter.
// - The stack has exactly four levels, used only for call and return addresses.
module call_return_stack
   import call_return_stack_pkg::*;
(
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [`REG_W-1:0] REG_ADDR,
   input wire logic [`REG_W-1:0] REG_WDATA,
   output logic [`REG_W-1:0] REG_RDATA,
   output logic REG_RVALID,
   input wire logic CALL,
   input wire logic RET,
   input wire logic STEP,
   input wire logic [`ADDR_W-1:0] CALL_TARGET,
   output logic [`ADDR_W-1:0] PROGRAM_COUNTER,
   output logic [`PTR_W-1:0] STACK_PTR,
   output logic RETURNED
);

   reg_req_s req;
   seq_cmd_s cmd;
   stack_state_s state_q;
   stack_state_s state_d;

   // Command kind after priority
   typedef enum logic [1:0] {
      OP_IDLE,
      OP_PUSH,
      OP_POP,
      OP_STEP
   } op_e;

   op_e op;
   logic do_push;
   logic do_pop;

   // Address decode, one bit per mapped byte
   logic hit_ptr;
   logic [`STACK_DEPTH-1:0] hit_hi;
   logic [`STACK_DEPTH-1:0] hit_lo;

   // Software write strobes per field
   logic wr_ptr;
   logic [`STACK_DEPTH-1:0] wr_hi;
   logic [`STACK_DEPTH-1:0] wr_lo;

   // Read contributions; decode is one-hot, so an OR acts as the mux
   logic [`REG_W-1:0] rd_ptr_byte;
   logic [`REG_W-1:0] rd_hi_byte [`STACK_DEPTH];
   logic [`REG_W-1:0] rd_lo_byte [`STACK_DEPTH];
   logic [`REG_W-1:0] rd_byte;
   logic [`REG_W-1:0] rdata_nxt;

   // Pointer, slot indices and addresses seen by this cycle's stack op
   ptr_t sp_eff;
   ptr_t sp_nxt;
   ptr_t push_idx;
   ptr_t pop_idx;
   ret_addr_t ret_pc;
   ret_addr_t pop_pc;
   ret_addr_t pc_nxt;

   // Per-slot push strobes and next slot contents
   logic [`STACK_DEPTH-1:0] push_we;
   logic [`HI_W-1:0] slot_hi_nxt [`STACK_DEPTH];
   logic [`LO_W-1:0] slot_lo_nxt [`STACK_DEPTH];

   // Slot for a push is the inverted pointer: 11->0, 10->1, 01->2, 00->3
   function automatic ptr_t push_slot(input ptr_t sp);
      push_slot = ~sp;
   endfunction

   // A pop reads the slot of the incremented pointer
   function automatic ptr_t pop_slot(input ptr_t sp);
      ptr_t nxt;
      nxt = sp + `PTR_W'(1);
      pop_slot = ~nxt;
   endfunction

   // Core strobes share CLK with the sequencer, so no synchroniser
   assign req.wr = REG_WR;
   assign req.rd = REG_RD;
   assign req.addr = REG_ADDR;
   assign req.wdata = REG_WDATA;
   assign cmd.call = CALL;
   assign cmd.ret = RET;
   assign cmd.step = STEP;
   assign cmd.target = CALL_TARGET;

   // Call wins over return, return over step; the core never issues two at once
   always_comb begin
      op = OP_IDLE;
      if (cmd.call) begin
         op = OP_PUSH;
      end else if (cmd.ret) begin
         op = OP_POP;
      end else if (cmd.step) begin
         op = OP_STEP;
      end
   end

   // Strobes for the per-slot logic
   assign do_push = (op == OP_PUSH);
   assign do_pop = (op == OP_POP);

   assign hit_ptr = (req.addr == `OFS_STACK_PTR);
   assign wr_ptr = req.wr & hit_ptr;

   // Unused upper bits of the pointer byte read zero
   always_comb begin
      rd_ptr_byte = 8'h00;
      if (hit_ptr) begin
         rd_ptr_byte[`PTR_FIELD_MSB:`PTR_FIELD_LSB] = state_q.sp;
      end
   end

   // A stack op in a write cycle indexes with the freshly written pointer
   always_comb begin
      sp_eff = state_q.sp;
      if (wr_ptr) begin
         sp_eff = req.wdata[`PTR_FIELD_MSB:`PTR_FIELD_LSB];
      end
   end

   // Push and pop index from the same pointer
   assign push_idx = push_slot(sp_eff);
   assign pop_idx = pop_slot(sp_eff);

   // Save first, then jump: the return lands on the word after the call
   assign ret_pc = state_q.pc + `PC_STEP;

   // Slot n: low byte at base+2n, high byte at base+2n+1; 0F8H stays unmapped
   genvar gi;
   generate
      for (gi = 0; gi < `STACK_DEPTH; gi++) begin : g_slot
         localparam logic [`REG_W-1:0] LO_OFS = `OFS_SLOT_BASE + 8'(2 * gi);
         localparam logic [`REG_W-1:0] HI_OFS = LO_OFS + 8'h01;

         assign hit_lo[gi] = (req.addr == LO_OFS);
         assign hit_hi[gi] = (req.addr == HI_OFS);
         assign wr_lo[gi] = req.wr & hit_lo[gi];
         assign wr_hi[gi] = req.wr & hit_hi[gi];

         // Slot index wraps with the pointer
         assign push_we[gi] = do_push & (push_idx == `PTR_W'(gi));

         // Only address bits 10:8 live in the high byte
         always_comb begin
            rd_hi_byte[gi] = 8'h00;
            if (hit_hi[gi]) begin
               rd_hi_byte[gi][`HI_FIELD_MSB:`HI_FIELD_LSB] = state_q.slot_hi[gi];
            end
         end

         always_comb begin
            rd_lo_byte[gi] = 8'h00;
            if (hit_lo[gi]) begin
               rd_lo_byte[gi] = state_q.slot_lo[gi];
            end
         end

         // A push wins over a software write to the same byte
         always_comb begin
            slot_hi_nxt[gi] = state_q.slot_hi[gi];
            if (push_we[gi]) begin
               slot_hi_nxt[gi] = ret_pc[`ADDR_W-1:`LO_W];
            end else if (wr_hi[gi]) begin
               slot_hi_nxt[gi] = req.wdata[`HI_FIELD_MSB:`HI_FIELD_LSB];
            end
         end

         always_comb begin
            slot_lo_nxt[gi] = state_q.slot_lo[gi];
            if (push_we[gi]) begin
               slot_lo_nxt[gi] = ret_pc[`LO_W-1:0];
            end else if (wr_lo[gi]) begin
               slot_lo_nxt[gi] = req.wdata;
            end
         end
      end
   endgenerate

   // Unmapped addresses leave every contribution at zero
   always_comb begin
      rd_byte = rd_ptr_byte;
      for (int i = 0; i < `STACK_DEPTH; i++) begin
         rd_byte = rd_byte | rd_hi_byte[i] | rd_lo_byte[i];
      end
   end

   // Read data holds until the next read
   always_comb begin
      rdata_nxt = state_q.rdata;
      if (req.rd) begin
         // Read sees the value before any same-cycle write
         rdata_nxt = rd_byte;
      end
   end

   // Return address as left by a same-cycle software write
   always_comb begin
      pop_pc = {state_q.slot_hi[pop_idx], state_q.slot_lo[pop_idx]};
      if (wr_hi[pop_idx]) begin
         pop_pc[`ADDR_W-1:`LO_W] = req.wdata[`HI_FIELD_MSB:`HI_FIELD_LSB];
      end
      if (wr_lo[pop_idx]) begin
         pop_pc[`LO_W-1:0] = req.wdata;
      end
   end

   // Pointer wraps modulo four both ways; no overflow flag is kept
   always_comb begin
      case (op)
         OP_PUSH: begin
            sp_nxt = sp_eff - `PTR_W'(1);
         end
         OP_POP: begin
            sp_nxt = sp_eff + `PTR_W'(1);
         end
         default: begin
            sp_nxt = sp_eff;
         end
      endcase
   end

   // Step and return both land on a stored or counted word
   always_comb begin
      case (op)
         OP_PUSH: begin
            pc_nxt = cmd.target;
         end
         OP_POP: begin
            pc_nxt = pop_pc;
         end
         OP_STEP: begin
            pc_nxt = ret_pc;
         end
         default: begin
            pc_nxt = state_q.pc;
         end
      endcase
   end

   // One register stage for all state
   always_comb begin
      state_d = state_q;
      // Pointer after the software write and the stack op
      state_d.sp = sp_nxt;
      for (int i = 0; i < `STACK_DEPTH; i++) begin
         state_d.slot_hi[i] = slot_hi_nxt[i];
         state_d.slot_lo[i] = slot_lo_nxt[i];
      end
      state_d.pc = pc_nxt;
      state_d.rdata = rdata_nxt;
      state_d.rvalid = req.rd;
      state_d.popped = do_pop;
   end

   // Every reset source lands here; execution restarts at zero
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         state_q.sp <= `RST_STACK_PTR;
         // Slots clear to zero
         for (int i = 0; i < `STACK_DEPTH; i++) begin
            state_q.slot_hi[i] <= `RST_SLOT_HI;
            state_q.slot_lo[i] <= `RST_SLOT_LO;
         end
         state_q.pc <= `RST_PC;
         state_q.rdata <= `RST_RDATA;
         state_q.rvalid <= 1'b0;
         state_q.popped <= 1'b0;
      end else begin
         state_q <= state_d;
      end
   end

   // Every output comes straight from state_q
   assign REG_RDATA = state_q.rdata;
   assign REG_RVALID = state_q.rvalid;
   assign PROGRAM_COUNTER = state_q.pc;
   assign STACK_PTR = state_q.sp;
   assign RETURNED = state_q.popped;

endmodule

/* inc/call_return_stack_defs.svh */
`ifndef CALL_RETURN_STACK_DEFS_SVH
`define CALL_RETURN_STACK_DEFS_SVH

`define STACK_DEPTH 4
`define PTR_W 2
`define ADDR_W 11
`define HI_W 3
`define LO_W 8
`define REG_W 8

`define OFS_STACK_PTR 8'hdf
`define OFS_SLOT_BASE 8'hf0
`define OFS_SLOT_LAST 8'hf8

`define PTR_FIELD_MSB 1
`define PTR_FIELD_LSB 0
`define HI_FIELD_MSB 2
`define HI_FIELD_LSB 0

`define RST_STACK_PTR 2'h3
`define RST_SLOT_HI 3'h0
`define RST_SLOT_LO 8'h00
`define RST_PC 11'h000
`define RST_RDATA 8'h00
`define PC_STEP 11'h001

`endif

/* inc/call_return_stack_pkg.sv */
`include "call_return_stack_defs.svh"

package call_return_stack_pkg;

   typedef logic [`PTR_W-1:0] ptr_t;
   typedef logic [`ADDR_W-1:0] ret_addr_t;

   // Register access from the core onto bank 0
   typedef struct packed {
      logic wr;
      logic rd;
      logic [`REG_W-1:0] addr;
      logic [`REG_W-1:0] wdata;
   } reg_req_s;

   // Sequencer commands
   typedef struct packed {
      logic call;
      logic ret;
      logic step;
      ret_addr_t target;
   } seq_cmd_s;

   typedef struct packed {
      ptr_t sp;
      logic [`STACK_DEPTH-1:0][`HI_W-1:0] slot_hi;
      logic [`STACK_DEPTH-1:0][`LO_W-1:0] slot_lo;
      ret_addr_t pc;
      logic [`REG_W-1:0] rdata;
      logic rvalid;
      logic popped;
   } stack_state_s;

endpackage

/* tb/call_return_stack_assertions.sv */
`timescale 1ns/10ps
module call_return_stack_assertions (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_RDATA,
   input wire logic REG_RVALID,
   input wire logic CALL,
   input wire logic RET,
   input wire logic [10:0] CALL_TARGET,
   input wire logic [10:0] PROGRAM_COUNTER,
   input wire logic [1:0] STACK_PTR,
   input wire logic RETURNED
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   sequence s_push; CALL && !REG_WR; endsequence
   sequence s_pop; RET && !CALL && !REG_WR; endsequence
   a_push_ptr: assert property (s_push |=> STACK_PTR == $past(STACK_PTR) - 2'h1)
      else $error("push ptr");
   a_pop_ptr: assert property (s_pop |=> STACK_PTR == $past(STACK_PTR) + 2'h1)
      else $error("pop ptr");
   a_call_load: assert property (CALL |=> PROGRAM_COUNTER == $past(CALL_TARGET))
      else $error("call pc");
   a_ret_flag: assert property (1 |=> RETURNED == $past(RET && !CALL))
      else $error("ret flag");
   a_rd_valid: assert property (1 |=> REG_RVALID == $past(REG_RD))
      else $error("rd valid");
   a_ptr_read: assert property (REG_RD && REG_ADDR == 8'hdf |=>
      REG_RDATA == {6'h00, $past(STACK_PTR)}) else $error("ptr read");
   a_ptr_hold: assert property (!CALL && !RET && !REG_WR |=> $stable(STACK_PTR))
      else $error("ptr moved");
   a_lifo_pair: assert property (s_push ##1 s_pop |=> STACK_PTR == $past(STACK_PTR, 2) &&
      PROGRAM_COUNTER == $past(PROGRAM_COUNTER, 2) + 11'h001) else $error("lifo");
endmodule
bind call_return_stack call_return_stack_assertions u_chk (.CLK(CLK), .RST_N(RST_N),
   .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_RDATA(REG_RDATA),
   .REG_RVALID(REG_RVALID), .CALL(CALL), .RET(RET), .CALL_TARGET(CALL_TARGET),
   .PROGRAM_COUNTER(PROGRAM_COUNTER), .STACK_PTR(STACK_PTR), .RETURNED(RETURNED));

/* tb/seq_model.sv */
`timescale 1ns/10ps
module seq_model
   import call_return_stack_pkg::*;
(
   input wire logic clk,
   output seq_cmd_s cmd
);
   initial cmd = '0;
   // Held until the next op; chained calls give back to back ops
   task automatic op(input logic c, r, s, input ret_addr_t t);
      @(posedge clk);
      #1 cmd = '{call: c, ret: r, step: s, target: t};
   endtask
endmodule

/* tb/call_return_stack_tb.sv */
`timescale 1ns/10ps
module call_return_stack_tb
   import call_return_stack_pkg::*;
;
   logic clk = 0, rst_n = 0, wr = 0, rd = 0, rv, rt;
   logic [7:0] ad = '0, wd = '0, rdat;
   logic [10:0] pc;
   logic [1:0] sp;
   seq_cmd_s cmd;
   int n_mismatch = 0, checked = 0;
   always #20 clk = ~clk;
   seq_model seq (.clk(clk), .cmd(cmd));
   call_return_stack dut (.CLK(clk), .RST_N(rst_n), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(ad),
      .REG_WDATA(wd), .REG_RDATA(rdat), .REG_RVALID(rv), .CALL(cmd.call), .RET(cmd.ret),
      .STEP(cmd.step), .CALL_TARGET(cmd.target), .PROGRAM_COUNTER(pc), .STACK_PTR(sp),
      .RETURNED(rt));
   task automatic chk(input logic [10:0] g, e);
      checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   // Read compares data against d and valid against 1
   task automatic acc(input logic w, input logic [7:0] a, d);
      @(posedge clk);
      #1 {wr, rd, ad, wd} = {w, !w, a, d};
      @(posedge clk);
      #1 {wr, rd} = 2'b00;
      if (!w) chk({2'b00, rv, rdat}, {3'b001, d});
   endtask
   task automatic wrap_up;
      $display("checked %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic t_reset;
      acc(0, 8'hdf, 8'h03);
      for (int a = 'hf0; a < 'hf8; a++) acc(0, 8'(a), 8'h00);
      chk(pc, 11'h000);
   endtask
   task automatic t_regs;
      acc(1, 8'hdf, 8'hfd);
      acc(0, 8'hdf, 8'h01);
      acc(1, 8'hf8, 8'hff);
      acc(0, 8'hf8, 8'h00);
      acc(1, 8'hf3, 8'hff);
      acc(0, 8'hf3, 8'h07);
      acc(1, 8'hdf, 8'h03);
   endtask
   task automatic t_fill;
      logic [10:0] e;
      logic [10:0] st [4];
      seq.op(0, 0, 1, 11'h000);
      e = 11'h001;
      for (int i = 0; i < 4; i++) begin
         st[i] = e + 11'h001;
         e = 11'h1a5 + 11'(i * 'h211);
         seq.op(1, 0, 0, e);
      end
      seq.op(0, 0, 0, 11'h000);
      chk(sp, 2'h3);
      chk(pc, e);
      for (int n = 0; n < 4; n++) begin
         acc(0, 8'(8'hf0 + 2 * n), st[n][7:0]);
         acc(0, 8'(8'hf1 + 2 * n), {5'h00, st[n][10:8]});
      end
      for (int i = 3; i >= 0; i--) begin
         seq.op(0, 1, 0, 11'h000);
         seq.op(0, 0, 0, 11'h000);
         chk(pc, st[i]);
         chk(rt, 11'h001);
      end
      chk(sp, 2'h3);
   endtask
   task automatic t_over;
      for (int i = 0; i < 5; i++) seq.op(1, 0, 0, 11'(i));
      seq.op(0, 1, 0, 11'h000);
      seq.op(0, 0, 0, 11'h000);
      chk(pc, 11'h004);
      chk(sp, 2'h3);
      acc(0, 8'hf0, 8'h04);
   endtask
   initial begin
      repeat (2) @(posedge clk);
      #1 rst_n = 1;
      t_reset;
      t_regs;
      t_fill;
      t_over;
      @(posedge clk);
      #1 rst_n = 0;
      #1 chk(pc, 11'h000);
      chk({9'h000, sp}, 11'h003);
      @(posedge clk);
      #1 rst_n = 1;
      t_reset;
      wrap_up;
   end
   initial begin
      #100000;
      n_mismatch++;
      wrap_up;
   end
endmodule
